// ===== eoc_pkg.sv
// Package of the external oscillator control block: offsets, fields,
// reset values, counts, state codes and carrier structs.
// Assumes a single 200 MHz core clock domain.
package eoc_pkg;

  // Register byte addresses
  localparam logic [7:0] EOC_IRQ_FLAG_OFS = 8'h04;
  localparam logic [7:0] EOC_IRQ_MASK_OFS = 8'h08;
  localparam logic [7:0] EOC_STATUS_OFS = 8'h0c;
  localparam logic [7:0] EOC_CTRL_OFS = 8'h10;

  // Control register fields
  localparam int EOC_ENABLE_BIT = 1;
  localparam int EOC_XSEL_BIT = 2;
  localparam int EOC_STBY_BIT = 6;
  localparam int EOC_ONDEM_BIT = 7;
  localparam int EOC_GAIN_LSB = 8;
  localparam int EOC_AGC_BIT = 11;
  localparam int EOC_WARM_LSB = 12;
  localparam logic [15:0] EOC_CTRL_RESET = 16'h0080;
  localparam logic [15:0] EOC_CTRL_WMASK = 16'hffc6;
  localparam logic [15:0] EOC_GAIN_MASK = 16'h0700;

  // Status register fields
  localparam int EOC_ST_XTAL = 0;
  localparam int EOC_ST_SLOWX = 1;
  localparam int EOC_ST_SLOWRC = 2;
  localparam int EOC_ST_FASTRC = 3;
  localparam int EOC_ST_LOOPRDY = 4;
  localparam int EOC_ST_OOB = 5;
  localparam int EOC_ST_W = 6;

  // Gain codes and counts
  localparam logic [2:0] EOC_GAIN_MAX = 3'h4;
  localparam logic [2:0] EOC_GAIN_MIN = 3'h0;
  localparam logic [1:0] EOC_SYNC_CYCLES = 2'h3;
  localparam int EOC_WARM_W = 17;
  localparam logic [16:0] EOC_WARM_ONE = 17'h00001;

  // Pin inputs passing the synchroniser
  localparam int EOC_PIN_W = 9;

  typedef enum logic [3:0] {
    EOC_OFF = 4'h1,
    EOC_WARM = 4'h2,
    EOC_SYNC = 4'h4,
    EOC_READY = 4'h8
  } eoc_state_t;

  // Register port request
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } eoc_req_t;

  // Oscillator steering outputs
  typedef struct packed {
    logic run;
    logic crystal_select;
    logic gpio_free;
    logic auto_gain_on;
    logic [2:0] gain;
  } eoc_osc_t;

endpackage : eoc_pkg

// ===== eoc_sync.sv
// Two-flop synchroniser bank for pin-level inputs.
// Assumes inputs are levels or slow clocks well below core_clk.
`timescale 1ns/1ps
`default_nettype none
module eoc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  // One pair of flops per bit; the first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic meta_q;
      logic stable_q;
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_q <= 1'b0;
          stable_q <= 1'b0;
        end else begin
          meta_q <= async_in[i];
          stable_q <= meta_q;
        end
      end
      assign sync_out[i] = stable_q;
    end
  endgenerate

endmodule : eoc_sync
`default_nettype wire

// ===== eoc_ctrl.sv
// External multipurpose crystal oscillator control: control register,
// warm-up and sync counting, gating, status, interrupt flags.
// Assumes the slow RC clock, crystal clock and analog status come from
// pins and must be synchronised; request and standby are core-clock logic.
//
// Added by the designer: the strobed register port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - status bit reads one while the locked loop reports out of bounds.
// - loop sync ready reads one when synchronisation complete, zero while ongoing.
// - each oscillator ready bit is one only when that oscillator is stable.
// - warm-up field bits 15:12 selects two to the power field slow cycles.
// - warm-up counter advances on ultra low power slow clock edges only.
// - after warm-up, wait three crystal cycles before raising crystal ready.
// - auto amplitude gain bit 11 set lets hardware adjust gain itself.
// - gain field bits 10:8 picks gain; codes five to seven are reserved.
// - gain field writes are ignored while auto gain control is active.
// - with request gated run set, oscillator runs only on peripheral request.
// - with request gated run clear, enabled oscillator runs continuously.
// - standby keep running clear stops the oscillator in standby.
// - standby keep running set keeps normal gating in standby.
// - enable bit one starts the oscillator, zero stops it.
// - crystal select zero uses input pad clock, frees output pad.
// - interrupt flag sets on status rise; enabled flags raise interrupt.
module eoc_ctrl
  import eoc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic write_protect_on,
  input wire logic ulp_clk_pin,
  input wire logic osc_clk_pin,
  input wire logic fast_rc_ok_pin,
  input wire logic slow_rc_ok_pin,
  input wire logic slow_crystal_ok_pin,
  input wire logic loop_sync_busy_pin,
  input wire logic loop_out_of_bounds_pin,
  input wire logic amp_low_pin,
  input wire logic amp_high_pin,
  input wire logic periph_clk_req,
  input wire logic standby_mode,
  output logic osc_run,
  output logic crystal_select,
  output logic osc_output_pad_gpio_free,
  output logic auto_amplitude_gain,
  output logic [2:0] osc_gain,
  output logic crystal_ready,
  output logic irq
);

  // Whole state of the block
  typedef struct packed {
    eoc_state_t st;
    logic [EOC_WARM_W-1:0] warm_cnt;
    logic [1:0] sync_cnt;
    logic [15:0] ctrl;
    logic [EOC_ST_W-1:0] flag;
    logic [EOC_ST_W-1:0] mask;
    logic [EOC_ST_W-1:0] prev_status;
    logic [2:0] agc_gain;
    logic ulp_prev;
    logic osc_prev;
    logic [31:0] rdata;
  } eoc_regs_t;

  eoc_regs_t s_q;
  eoc_regs_t s_d;
  eoc_req_t req;
  eoc_osc_t osc;
  logic [EOC_PIN_W-1:0] pins_raw;
  logic [EOC_PIN_W-1:0] pins;
  logic ulp_edge;
  logic osc_edge;
  logic run_now;
  logic [EOC_ST_W-1:0] status;
  logic [EOC_ST_W-1:0] rise;
  logic [15:0] wmask;
  logic [3:0] warm_sel;

  // Group bus signals into one carrier
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  // Pins cross into core_clk before any logic looks at them
  assign pins_raw = {amp_high_pin, amp_low_pin, loop_out_of_bounds_pin,
                     loop_sync_busy_pin, slow_crystal_ok_pin, slow_rc_ok_pin,
                     fast_rc_ok_pin, osc_clk_pin, ulp_clk_pin};

  eoc_sync #(
    .WIDTH(EOC_PIN_W)
  ) u_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .async_in(pins_raw),
    .sync_out(pins)
  );

  // Rising edges of the two slow clocks as core-clock pulses
  assign ulp_edge = pins[0] & ~s_q.ulp_prev;
  assign osc_edge = pins[1] & ~s_q.osc_prev;

  // Run decision: enable, standby policy, then request gating
  always_comb begin
    run_now = s_q.ctrl[EOC_ENABLE_BIT];
    if (standby_mode && !s_q.ctrl[EOC_STBY_BIT]) begin
      run_now = 1'b0;
    end
    // Standby with keep-running falls through to normal gating
    if (s_q.ctrl[EOC_ONDEM_BIT] && !periph_clk_req) begin
      run_now = 1'b0;
    end
    // Without request gating the enable and the standby policy decide
  end

  // Live status word; loop ready taken as one meaning sync complete
  always_comb begin
    status = '0;
    status[EOC_ST_XTAL] = s_q.st == EOC_READY;
    status[EOC_ST_SLOWX] = pins[4];
    status[EOC_ST_SLOWRC] = pins[3];
    status[EOC_ST_FASTRC] = pins[2];
    status[EOC_ST_LOOPRDY] = ~pins[5];
    status[EOC_ST_OOB] = pins[6];
  end

  assign rise = status & ~s_q.prev_status;

  // Gain bits are frozen while auto gain is on
  always_comb begin
    wmask = EOC_CTRL_WMASK;
    if (s_q.ctrl[EOC_AGC_BIT]) begin
      wmask = EOC_CTRL_WMASK & ~EOC_GAIN_MASK;
    end
  end

  assign warm_sel = s_q.ctrl[EOC_WARM_LSB +: 4];

  // Next-state logic for the whole block
  always_comb begin
    s_d = s_q;
    s_d.ulp_prev = pins[0];
    s_d.osc_prev = pins[1];
    s_d.prev_status = status;
    s_d.rdata = '0;

    // Register writes; write protection blocks control changes only
    if (req.wr) begin
      case (req.addr)
        EOC_CTRL_OFS: begin
          if (!write_protect_on) begin
            s_d.ctrl = (s_q.ctrl & ~wmask) | (req.wdata[15:0] & wmask);
          end
        end
        EOC_IRQ_FLAG_OFS: begin
          s_d.flag = s_q.flag & ~req.wdata[EOC_ST_W-1:0];
        end
        EOC_IRQ_MASK_OFS: begin
          s_d.mask = req.wdata[EOC_ST_W-1:0];
        end
        default: begin
        end
      endcase
    end
    // Set after clear so a same-cycle event is never lost
    s_d.flag = s_d.flag | rise;

    // Read data stand in the cycle after the strobe
    if (req.rd) begin
      case (req.addr)
        EOC_CTRL_OFS: s_d.rdata = {16'h0000, s_q.ctrl};
        EOC_STATUS_OFS: s_d.rdata = {26'h0000000, status};
        EOC_IRQ_FLAG_OFS: s_d.rdata = {26'h0000000, s_q.flag};
        EOC_IRQ_MASK_OFS: s_d.rdata = {26'h0000000, s_q.mask};
        default: s_d.rdata = '0;
      endcase
    end

    // Auto gain steps one code per core cycle while one amplitude pin is high, clamped to 0..4
    if (!s_q.ctrl[EOC_AGC_BIT]) begin
      s_d.agc_gain = s_q.ctrl[EOC_GAIN_LSB +: 3];
    end else if (pins[7] && !pins[8] && s_q.agc_gain < EOC_GAIN_MAX) begin
      s_d.agc_gain = s_q.agc_gain + 3'h1;
    end else if (pins[8] && !pins[7] && s_q.agc_gain > EOC_GAIN_MIN) begin
      s_d.agc_gain = s_q.agc_gain - 3'h1;
    end

    // Start-up sequence; a stop anywhere drops back to off
    case (s_q.st)
      EOC_OFF: begin
        if (run_now) begin
          s_d.st = EOC_WARM;
          s_d.warm_cnt = EOC_WARM_ONE << warm_sel;
        end
      end
      EOC_WARM: begin
        if (ulp_edge) begin
          if (s_q.warm_cnt == EOC_WARM_ONE) begin
            s_d.st = EOC_SYNC;
            s_d.sync_cnt = EOC_SYNC_CYCLES;
          end else begin
            s_d.warm_cnt = s_q.warm_cnt - EOC_WARM_ONE;
          end
        end
      end
      EOC_SYNC: begin
        if (osc_edge) begin
          if (s_q.sync_cnt == 2'h1) begin
            s_d.st = EOC_READY;
          end else begin
            s_d.sync_cnt = s_q.sync_cnt - 2'h1;
          end
        end
      end
      EOC_READY: begin
      end
      default: begin
        s_d.st = EOC_OFF;
      end
    endcase
    if (!run_now) begin
      s_d.st = EOC_OFF;
      s_d.warm_cnt = '0;
      s_d.sync_cnt = '0;
    end
  end

  // Single state register
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{st: EOC_OFF, warm_cnt: '0, sync_cnt: '0,
               ctrl: EOC_CTRL_RESET, flag: '0, mask: '0,
               prev_status: '0, agc_gain: '0, ulp_prev: 1'b0,
               osc_prev: 1'b0, rdata: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // Oscillator steering from registered control; reserved codes pass on
  always_comb begin
    osc.run = run_now;
    osc.crystal_select = s_q.ctrl[EOC_XSEL_BIT];
    osc.gpio_free = ~s_q.ctrl[EOC_XSEL_BIT];
    osc.auto_gain_on = s_q.ctrl[EOC_AGC_BIT];
    osc.gain = s_q.ctrl[EOC_AGC_BIT] ? s_q.agc_gain
                                     : s_q.ctrl[EOC_GAIN_LSB +: 3];
  end

  assign osc_run = osc.run;
  assign crystal_select = osc.crystal_select;
  assign osc_output_pad_gpio_free = osc.gpio_free;
  assign auto_amplitude_gain = osc.auto_gain_on;
  assign osc_gain = osc.gain;
  assign crystal_ready = s_q.st == EOC_READY;
  assign reg_rdata = s_q.rdata;
  // Level interrupt while any enabled flag is set
  assign irq = |(s_q.flag & s_q.mask);

endmodule : eoc_ctrl
`default_nettype wire

// ===== eoc_ctrl_monitor.sv
// Port checker of the oscillator control block.
// Assumes it is bound to eoc_ctrl, one core clock domain.
`timescale 1ns/1ps
`default_nettype none
module eoc_ctrl_monitor (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic osc_run,
  input wire logic crystal_select,
  input wire logic osc_output_pad_gpio_free,
  input wire logic auto_amplitude_gain,
  input wire logic [2:0] osc_gain,
  input wire logic crystal_ready
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Pad and read port relations
  property p_pad; osc_output_pad_gpio_free == !crystal_select; endproperty
  a_pad: assert property (p_pad) else $error("pad free wrong");
  property p_rdata; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
  a_rdata: assert property (p_rdata) else $error("stray read data");
  // Ready follows the run gate
  property p_off; !osc_run |=> !crystal_ready; endproperty
  a_off: assert property (p_off) else $error("ready kept");
  property p_hold; crystal_ready && osc_run |=> crystal_ready; endproperty
  a_hold: assert property (p_hold) else $error("ready lost");
  // Warm-up plus sync can never be shorter than eight core cycles
  property p_rise; $rose(crystal_ready) |-> $past(osc_run, 8); endproperty
  a_rise: assert property (p_rise) else $error("ready early");
  property p_warm; $rose(osc_run) |-> !crystal_ready [*8]; endproperty
  a_warm: assert property (p_warm) else $error("no warm-up");
  // Gain moves only by write, or by single steps under auto control
  property p_gain;
    !auto_amplitude_gain && !$past(auto_amplitude_gain) && !$past(reg_wr)
      |-> $stable(osc_gain);
  endproperty
  a_gain: assert property (p_gain) else $error("gain drift");
  property p_step;
    auto_amplitude_gain && $past(auto_amplitude_gain)
      |-> (osc_gain - $past(osc_gain)) inside {3'h0, 3'h1, 3'h7};
  endproperty
  a_step: assert property (p_step) else $error("gain jump");
  c_rdy: cover property ($rose(crystal_ready));
  c_stop: cover property ($fell(osc_run));
  c_agc: cover property (auto_amplitude_gain && osc_gain == 3'h4);
endmodule : eoc_ctrl_monitor
bind eoc_ctrl eoc_ctrl_monitor u_eoc_ctrl_monitor (
  .core_clk(core_clk),
  .rst_n(rst_n),
  .reg_wr(reg_wr),
  .reg_rd(reg_rd),
  .reg_rdata(reg_rdata),
  .osc_run(osc_run),
  .crystal_select(crystal_select),
  .osc_output_pad_gpio_free(osc_output_pad_gpio_free),
  .auto_amplitude_gain(auto_amplitude_gain),
  .osc_gain(osc_gain),
  .crystal_ready(crystal_ready)
);
`default_nettype wire

// ===== eoc_xtal_model.sv
// Crystal at the pads: toggles only while the block runs it.
// Assumes a slow crystal, well below a quarter of the core clock.
`timescale 1ns/1ps
`default_nettype none
module eoc_xtal_model (
  input wire logic run,
  output logic osc_clk
);
  // Stopped crystal stands low, so no edge leaks out of a stop
  initial osc_clk = 1'b0;
  always begin
    #30;
    osc_clk = run ? ~osc_clk : 1'b0;
  end
endmodule : eoc_xtal_model
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench of the oscillator control block.
// Assumes eoc_pkg, eoc_ctrl and the crystal model compiled first.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eoc_pkg::*;
  logic core_clk, rst_n, reg_wr, reg_rd, wp, ulp, oclk, busy, oob;
  logic fast_ok, slow_ok, sx_ok, amp_lo, amp_hi, req, stby;
  logic run, xsel, gfree, agc, rdy, irq;
  logic [2:0] gain;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  int n_fail, checked;
  eoc_ctrl u_eoc_ctrl (.core_clk(core_clk), .rst_n(rst_n),
    .reg_addr(addr), .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdata), .write_protect_on(wp), .ulp_clk_pin(ulp),
    .osc_clk_pin(oclk), .fast_rc_ok_pin(fast_ok), .slow_rc_ok_pin(slow_ok),
    .slow_crystal_ok_pin(sx_ok), .loop_sync_busy_pin(busy),
    .loop_out_of_bounds_pin(oob), .amp_low_pin(amp_lo),
    .amp_high_pin(amp_hi), .periph_clk_req(req), .standby_mode(stby),
    .osc_run(run), .crystal_select(xsel), .osc_output_pad_gpio_free(gfree),
    .auto_amplitude_gain(agc), .osc_gain(gain), .crystal_ready(rdy),
    .irq(irq));
  eoc_xtal_model u_eoc_xtal_model (.run(run), .osc_clk(oclk));
  // Core clock 200 MHz; slow RC runs free and unrelated
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always #20 ulp = ~ulp;
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
      n_fail++;
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge core_clk);
    addr <= a;
    wdata <= v;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(rdata, e);
  endtask : rd
  // Limit per call so a wrong warm-up count shows up as a late ready
  task automatic wait_rdy(input int lim);
    for (int i = 0; i < lim && rdy !== 1'b1; i++) @(posedge core_clk);
    #1 chk({31'h0, rdy}, 32'h1);
  endtask : wait_rdy
  initial begin
    {reg_wr, reg_rd, wp, ulp, busy, oob, amp_lo, amp_hi, req, stby} = '0;
    {fast_ok, slow_ok, sx_ok} = 3'b101;
    addr = '0;
    wdata = '0;
    rst_n = 1'b0;
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(6);
    chk({31'h0, run}, 32'h0);
    chk({30'h0, xsel, gfree}, 32'h1);
    rd(EOC_CTRL_OFS, 32'h0080);
    rd(EOC_STATUS_OFS, 32'h1a);
    @(posedge core_clk);
    busy <= 1'b1;
    oob <= 1'b1;
    slow_ok <= 1'b1;
    cyc(6);
    rd(EOC_STATUS_OFS, 32'h2e);
    rd(EOC_IRQ_FLAG_OFS, 32'h3e);
    chk({31'h0, irq}, 32'h0);
    wr(EOC_IRQ_MASK_OFS, 32'h20);
    cyc(2);
    chk({31'h0, irq}, 32'h1);
    wr(EOC_IRQ_FLAG_OFS, 32'h20);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    rd(8'h20, 32'h0);
    // Warm-up of eight slow edges, then three crystal edges
    wr(EOC_CTRL_OFS, 32'h3006);
    cyc(60);
    chk({31'h0, rdy}, 32'h0);
    wait_rdy(80);
    chk({30'h0, xsel, gfree}, 32'h2);
    rd(EOC_STATUS_OFS, 32'h2f);
    wr(EOC_CTRL_OFS, 32'h3706);
    cyc(1);
    chk({29'h0, gain}, 32'h7);
    // Auto gain switched on here after the crystal is ready; it starts from code 3
    wr(EOC_CTRL_OFS, 32'h3306);
    wr(EOC_CTRL_OFS, 32'h3b06);
    amp_lo <= 1'b1;
    cyc(10);
    chk({28'h0, agc, gain}, 32'hc);
    wr(EOC_CTRL_OFS, 32'h3906);
    rd(EOC_CTRL_OFS, 32'h3b06);
    chk({29'h0, gain}, 32'h4);
    amp_lo <= 1'b0;
    amp_hi <= 1'b1;
    cyc(10);
    chk({29'h0, gain}, 32'h0);
    amp_hi <= 1'b0;
    wr(EOC_CTRL_OFS, 32'h3086);
    cyc(2);
    chk({30'h0, run, rdy}, 32'h0);
    req <= 1'b1;
    cyc(1);
    chk({31'h0, run}, 32'h1);
    wait_rdy(160);
    req <= 1'b0;
    wr(EOC_CTRL_OFS, 32'h3006);
    cyc(2);
    chk({31'h0, run}, 32'h1);
    stby <= 1'b1;
    cyc(1);
    chk({31'h0, run}, 32'h0);
    wr(EOC_CTRL_OFS, 32'h3046);
    cyc(1);
    chk({31'h0, run}, 32'h1);
    wr(EOC_CTRL_OFS, 32'h30c6);
    cyc(1);
    chk({31'h0, run}, 32'h0);
    wp <= 1'b1;
    wr(EOC_CTRL_OFS, 32'h0);
    rd(EOC_CTRL_OFS, 32'h30c6);
    wp <= 1'b0;
    wr(EOC_CTRL_OFS, 32'h0);
    cyc(1);
    chk({31'h0, run}, 32'h0);
    summarize();
  end
  // Whole run is a few microseconds; cut a hang well beyond that
  initial begin
    #50000;
    n_fail++;
    summarize();
  end
endmodule : tb_top
`default_nettype wire
